// [hw/rsc_pkg.sv]
// Package of constants and types for the multi-source reset controller
package rsc_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses on the Wishbone slave)
  // ------------------------------------------------------------
  localparam int          WB_AW       = 8;
  localparam int          WB_DW       = 32;
  localparam logic [7:0]  ADR_CTRL    = 8'h00;
  localparam logic [7:0]  ADR_STAT    = 8'h04;
  localparam logic [7:0]  ADR_BOOT    = 8'h08;
  localparam logic [7:0]  ADR_SYSCFG  = 8'h0c;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int          CTRL_HARD_B = 0;
  localparam int          CTRL_SOFT_B = 1;
  localparam int          CTRL_WDEN_B = 2;
  localparam int          STAT_BUSY_B = 8;
  localparam logic        WDEN_RST    = 1'b1;

  // ------------------------------------------------------------
  // Widths and default sequence lengths in clock cycles
  // ------------------------------------------------------------
  localparam int          CFG_W       = 8;
  localparam int          SRCSEL_W    = 3;
  localparam int          BOOT_W      = 32;
  localparam int          CNT_W       = 16;
  localparam int          SYNC_W      = 3 + CFG_W;
  localparam int          POR_CYC     = 64;
  localparam int          HARD_CYC    = 32;
  localparam int          SOFT_CYC    = 16;
  localparam int          GUARD_CYC   = 4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_POR,
    ST_HARD,
    ST_SOFT,
    ST_GUARD
  } rsc_state_t;

  // Which sources took part in a reset
  typedef struct packed {
    logic sw_soft;
    logic sw_hard;
    logic rio;
    logic tap;
    logic wdog;
    logic ext_soft;
    logic ext_hard;
    logic por;
  } rsc_src_t;

endpackage

// [hw/rsc_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module rsc_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,  // Device clock
  input  wire logic         rst_i,  // Synchronous reset, high
  input  wire logic [W-1:0] d_i,    // Asynchronous input
  output logic      [W-1:0] q_o     // Synchronised output
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // The first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= RST;
      q_ff    <= RST;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule

// [hw/rsc_ctrl.sv]
// Multi-source reset sequencer with Wishbone register access
// ------------------------------------------------------------
// Notes on behaviour
// - Power-on resets everything, drives both lines.
// - Boot word loads only during power-on input.
// - Soft line driven whenever hard line is.
// - Hard line open-drain: pull low or release.
// - Hard reset drives lines, cores, re-applies stored config.
// - Hard reset never reloads the boot word.
// - External soft seen only when not driving.
// - Soft line open-drain: pull low or release.
// - Soft reset drives soft line, keeps config.
// - Test port host command runs soft reset.
// - Enabled watchdog expiry runs hard reset.
// - Serial link request runs hard reset.
// - Software hard request bit runs hard reset.
// - Software soft request bit runs soft reset.
// - Status register records last reset sources.
// - Pins, PLL, source select only on power-on.
// ------------------------------------------------------------
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module rsc_ctrl
  import rsc_pkg::*;
#(
  parameter int P_POR_CYC   = POR_CYC,
  parameter int P_HARD_CYC  = HARD_CYC,
  parameter int P_SOFT_CYC  = SOFT_CYC,
  parameter int P_GUARD_CYC = GUARD_CYC
) (
  input  wire logic              clk_i,          // Device clock, 100 MHz
  input  wire logic              rst_i,          // Synchronous reset, high
  input  wire logic              wb_cyc_i,       // Wishbone cycle
  input  wire logic              wb_stb_i,       // Wishbone strobe
  input  wire logic              wb_we_i,        // Wishbone write enable
  input  wire logic [WB_AW-1:0]  wb_adr_i,       // Wishbone byte address
  input  wire logic [3:0]        wb_sel_i,       // Wishbone byte lanes
  input  wire logic [WB_DW-1:0]  wb_dat_i,       // Wishbone write data
  output logic      [WB_DW-1:0]  wb_dat_o,       // Wishbone read data
  output logic                   wb_ack_o,       // Wishbone acknowledge
  input  wire logic              power_on_reset_n_i, // Power-on pin, low
  input  wire logic              hard_reset_line_n_i, // Hard line level
  output logic                   hard_reset_line_n_o, // Hard line drive
  output logic                   hard_reset_line_oe_o, // Hard line pull
  input  wire logic              soft_reset_line_n_i, // Soft line level
  output logic                   soft_reset_line_n_o, // Soft line drive
  output logic                   soft_reset_line_oe_o, // Soft line pull
  input  wire logic [CFG_W-1:0]  cfg_pins_i,     // Configuration pins
  input  wire logic [BOOT_W-1:0] boot_word_i,    // Boot word source
  input  wire logic              wdog_zero_i,    // Watchdog count zero
  input  wire logic              tap_soft_req_i, // Test port host reset
  input  wire logic              rio_hard_req_i, // Serial link hard req
  output logic                   core_reset_o,   // Extended cores reset
  output logic                   pll_reset_o,    // PLL state reset
  output logic [SRCSEL_W-1:0]    cfg_src_sel_o,  // Config source select
  output logic [BOOT_W-1:0]      boot_configuration_word_o, // Boot word
  output logic [BOOT_W-1:0]      sys_cfg_o       // Applied system config
);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (P_POR_CYC < 1 || P_POR_CYC >= (1 << CNT_W) ||
      P_HARD_CYC < 1 || P_HARD_CYC >= (1 << CNT_W) ||
      P_SOFT_CYC < 1 || P_SOFT_CYC >= (1 << CNT_W)) begin : g_bad_cyc
    $error("rsc_ctrl: sequence length out of range");
  end
  // The guard must outlast the pin synchroniser so our own drive is not seen
  if (P_GUARD_CYC < 3 || P_GUARD_CYC >= (1 << CNT_W)) begin : g_bad_guard
    $error("rsc_ctrl: guard length out of range");
  end

  localparam logic [CNT_W-1:0] POR_LD   = CNT_W'(P_POR_CYC - 1);
  localparam logic [CNT_W-1:0] HARD_LD  = CNT_W'(P_HARD_CYC - 1);
  localparam logic [CNT_W-1:0] SOFT_LD  = CNT_W'(P_SOFT_CYC - 1);
  localparam logic [CNT_W-1:0] GUARD_LD = CNT_W'(P_GUARD_CYC - 1);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic              por_act;
  logic              hard_low;
  logic              soft_low;
  logic [CFG_W-1:0]  cfg_s;

  rsc_sync #(
    .W   (SYNC_W),
    .RST ({3'b111, {CFG_W{1'b0}}})
  ) rsc_sync_inst (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({power_on_reset_n_i, hard_reset_line_n_i,
             soft_reset_line_n_i, cfg_pins_i}),
    .q_o   (pins_s)
  );

  assign por_act  = ~pins_s[SYNC_W-1];
  assign hard_low = ~pins_s[SYNC_W-2];
  assign soft_low = ~pins_s[SYNC_W-3];
  assign cfg_s    = pins_s[CFG_W-1:0];

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic              ack_ff;
  logic [WB_DW-1:0]  rdat_ff;
  logic              wb_req;
  logic              wb_wr;
  logic              wden_ff;
  logic              sw_hard_set;
  logic              sw_soft_set;
  rsc_src_t          stat_ff;
  rsc_state_t        state_ff;
  logic [BOOT_W-1:0] boot_ff;
  logic [BOOT_W-1:0] syscfg_ff;

  function automatic logic hit(input logic [WB_AW-1:0] a,
                               input logic [7:0]       r);
    hit = (a[WB_AW-1:2] == r[WB_AW-1:2]);
  endfunction

  assign wb_req = wb_cyc_i & wb_stb_i;
  // A write takes effect on the edge that the master sees ack
  assign wb_wr  = wb_req & wb_we_i & ack_ff;

  assign sw_hard_set = wb_wr & hit(wb_adr_i, ADR_CTRL) & wb_sel_i[0] &
                       wb_dat_i[CTRL_HARD_B];
  assign sw_soft_set = wb_wr & hit(wb_adr_i, ADR_CTRL) & wb_sel_i[0] &
                       wb_dat_i[CTRL_SOFT_B];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_req & ~ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wden_ff <= WDEN_RST;
    end else if (wb_wr & hit(wb_adr_i, ADR_CTRL) & wb_sel_i[0]) begin
      wden_ff <= wb_dat_i[CTRL_WDEN_B];
    end
  end

  // Unmapped addresses answer with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= '0;
    end else if (wb_req & ~ack_ff) begin
      rdat_ff <= '0;
      if (hit(wb_adr_i, ADR_CTRL)) begin
        rdat_ff[CTRL_WDEN_B] <= wden_ff;
      end else if (hit(wb_adr_i, ADR_STAT)) begin
        rdat_ff[$bits(rsc_src_t)-1:0] <= stat_ff;
        rdat_ff[STAT_BUSY_B]          <= (state_ff != ST_IDLE);
      end else if (hit(wb_adr_i, ADR_BOOT)) begin
        rdat_ff[BOOT_W-1:0] <= boot_ff;
      end else if (hit(wb_adr_i, ADR_SYSCFG)) begin
        rdat_ff[BOOT_W-1:0] <= syscfg_ff;
      end
    end
  end

  // ------------------------------------------------------------
  // Pending internal requests
  // ------------------------------------------------------------
  logic       p_wdog_ff;
  logic       p_rio_ff;
  logic       p_swh_ff;
  logic       p_tap_ff;
  logic       p_sws_ff;
  logic       clr_hard;
  logic       clr_soft;
  logic       ext_hard;
  logic       ext_soft;
  logic       hard_req;
  logic       soft_req;
  rsc_src_t   src_now;

  // Set wins over clear, so while clr_hard is high only a request in its last high cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_wdog_ff <= 1'b0;
      p_rio_ff  <= 1'b0;
      p_swh_ff  <= 1'b0;
    end else begin
      p_wdog_ff <= (wdog_zero_i & wden_ff) | (p_wdog_ff & ~clr_hard);
      p_rio_ff  <= rio_hard_req_i | (p_rio_ff & ~clr_hard);
      p_swh_ff  <= sw_hard_set | (p_swh_ff & ~clr_hard);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_tap_ff <= 1'b0;
      p_sws_ff <= 1'b0;
    end else begin
      p_tap_ff <= tap_soft_req_i | (p_tap_ff & ~clr_soft);
      p_sws_ff <= sw_soft_set | (p_sws_ff & ~clr_soft);
    end
  end

  // Pins are only trusted while this end is not pulling them
  assign ext_hard = hard_low & ((state_ff == ST_IDLE) | (state_ff == ST_SOFT));
  assign ext_soft = soft_low & (state_ff == ST_IDLE);
  assign hard_req = ext_hard | p_wdog_ff | p_rio_ff | p_swh_ff;
  assign soft_req = ext_soft | p_tap_ff | p_sws_ff;

  always_comb begin
    src_now          = '0;
    src_now.por      = por_act;
    src_now.ext_hard = ext_hard;
    src_now.ext_soft = ext_soft;
    src_now.wdog     = p_wdog_ff;
    src_now.tap      = p_tap_ff;
    src_now.rio      = p_rio_ff;
    src_now.sw_hard  = p_swh_ff;
    src_now.sw_soft  = p_sws_ff;
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  rsc_state_t       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             start;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff != '0) ? cnt_ff - CNT_W'(1) : '0;
    if (por_act) begin
      nxt_state = ST_POR;
      nxt_cnt   = POR_LD;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (hard_req) begin
            nxt_state = ST_HARD;
            nxt_cnt   = HARD_LD;
          end else if (soft_req) begin
            nxt_state = ST_SOFT;
            nxt_cnt   = SOFT_LD;
          end
        end
        ST_SOFT: begin
          if (hard_req) begin
            nxt_state = ST_HARD;
            nxt_cnt   = HARD_LD;
          end else if (cnt_ff == '0) begin
            nxt_state = ST_GUARD;
            nxt_cnt   = GUARD_LD;
          end
        end
        ST_POR, ST_HARD: begin
          if (cnt_ff == '0) begin
            nxt_state = ST_GUARD;
            nxt_cnt   = GUARD_LD;
          end
        end
        ST_GUARD: begin
          if (cnt_ff == '0) begin
            nxt_state = ST_IDLE;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_cnt   = '0;
        end
      endcase
    end
  end

  // A sequence starts whenever the state climbs to a stronger reset
  assign start    = ((nxt_state == ST_POR) & (state_ff != ST_POR)) |
                    ((nxt_state == ST_HARD) & (state_ff != ST_HARD)) |
                    ((nxt_state == ST_SOFT) & (state_ff != ST_SOFT));
  assign clr_hard = (nxt_state == ST_HARD) | (nxt_state == ST_POR);
  assign clr_soft = clr_hard | (nxt_state == ST_SOFT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= '0;
    end else if (start) begin
      stat_ff <= src_now;
    end
  end

  // ------------------------------------------------------------
  // Configuration capture
  // ------------------------------------------------------------
  logic [SRCSEL_W-1:0] srcsel_ff;
  logic                seq_end;

  // Pins and the boot word are only taken while the power-on input is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_ff   <= '0;
      srcsel_ff <= '0;
    end else if (por_act) begin
      boot_ff   <= boot_word_i;
      srcsel_ff <= cfg_s[SRCSEL_W-1:0];
    end
  end

  // System config is re-applied from the stored word; soft keeps it
  assign seq_end = (cnt_ff == '0) & ~por_act &
                   ((state_ff == ST_POR) | (state_ff == ST_HARD));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      syscfg_ff <= '0;
    end else if (seq_end) begin
      syscfg_ff <= boot_ff;
    end
  end

  // ------------------------------------------------------------
  // Output drive
  // ------------------------------------------------------------
  logic drv_hard_ff;
  logic drv_soft_ff;
  logic core_ff;
  logic pll_ff;
  logic low_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_hard_ff <= 1'b0;
      drv_soft_ff <= 1'b0;
      core_ff     <= 1'b0;
      pll_ff      <= 1'b0;
    end else begin
      drv_hard_ff <= (nxt_state == ST_POR) | (nxt_state == ST_HARD);
      drv_soft_ff <= (nxt_state == ST_POR) | (nxt_state == ST_HARD) |
                     (nxt_state == ST_SOFT);
      core_ff     <= (nxt_state == ST_POR) | (nxt_state == ST_HARD) |
                     (nxt_state == ST_SOFT);
      pll_ff      <= (nxt_state == ST_POR);
    end
  end

  // Open-drain data is always low; only the enable ever changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_ff <= 1'b0;
    end else begin
      low_ff <= 1'b0;
    end
  end

  assign wb_ack_o                  = ack_ff;
  assign wb_dat_o                  = rdat_ff;
  assign hard_reset_line_n_o       = low_ff;
  assign hard_reset_line_oe_o      = drv_hard_ff;
  assign soft_reset_line_n_o       = low_ff;
  assign soft_reset_line_oe_o      = drv_soft_ff;
  assign core_reset_o              = core_ff;
  assign pll_reset_o               = pll_ff;
  assign cfg_src_sel_o             = srcsel_ff;
  assign boot_configuration_word_o = boot_ff;
  assign sys_cfg_o                 = syscfg_ff;

endmodule

// [bench/rsc_board_model.sv]
// Board side of the reset pins: power-on switch and open-drain pulls
`timescale 1ns/1ps
module rsc_board_model (
  input  wire logic por_hold_i,         // Hold the power-on pin low
  input  wire logic pull_hard_i,        // Board pulls the hard line
  input  wire logic pull_soft_i,        // Board pulls the soft line
  input  wire logic hard_oe_i,          // Device pulls the hard line
  input  wire logic hard_drv_n_i,       // Device level on the hard line
  input  wire logic soft_oe_i,          // Device pulls the soft line
  input  wire logic soft_drv_n_i,       // Device level on the soft line
  output logic      power_on_reset_n_o, // Power-on pin
  output logic      hard_line_n_o,      // Resolved hard line
  output logic      soft_line_n_o       // Resolved soft line
);
  // ----------------------------------------------------------
  // Pull-ups win whenever nobody pulls, so a release reads high
  // ----------------------------------------------------------
  assign power_on_reset_n_o = !por_hold_i;
  assign hard_line_n_o = !((hard_oe_i && !hard_drv_n_i) || pull_hard_i);
  assign soft_line_n_o = !((soft_oe_i && !soft_drv_n_i) || pull_soft_i);
endmodule

// [bench/rsc_ctrl_props.sv]
// Checker of reset drive, boot word and bus timing of the reset controller
`timescale 1ns/1ps
module rsc_ctrl_props
  import rsc_pkg::*;
#(
  parameter int P_HARD_CYC = HARD_CYC,
  parameter int P_SOFT_CYC = SOFT_CYC
) (
  input wire logic                clk_i,                     // Clock
  input wire logic                rst_i,                     // Reset, high
  input wire logic                wb_cyc_i,                  // Bus cycle
  input wire logic                wb_stb_i,                  // Bus strobe
  input wire logic                wb_ack_o,                  // Bus acknowledge
  input wire logic                power_on_reset_n_i,        // Power-on pin
  input wire logic                hard_reset_line_n_o,       // Hard drive
  input wire logic                hard_reset_line_oe_o,      // Hard pull
  input wire logic                soft_reset_line_n_o,       // Soft drive
  input wire logic                soft_reset_line_oe_o,      // Soft pull
  input wire logic                core_reset_o,              // Cores reset
  input wire logic                pll_reset_o,               // PLL reset
  input wire logic [SRCSEL_W-1:0] cfg_src_sel_o,             // Source select
  input wire logic [BOOT_W-1:0]   boot_configuration_word_o  // Boot word
);
  logic [15:0] hard_cnt_ff;
  logic [15:0] soft_cnt_ff;
  logic [3:0]  por_age_ff;
  // ----------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    hard_cnt_ff <= (rst_i || !hard_reset_line_oe_o) ? 16'h0 : hard_cnt_ff + 16'h1;
  end
  always_ff @(posedge clk_i) begin
    soft_cnt_ff <= (rst_i || !soft_reset_line_oe_o) ? 16'h0 : soft_cnt_ff + 16'h1;
  end
  // Saturates, so power-on time is while the pin is low and the first cycles after it rises
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_age_ff <= 4'hf;
    end else if (!power_on_reset_n_i) begin
      por_age_ff <= 4'h0;
    end else if (por_age_ff != 4'hf) begin
      por_age_ff <= por_age_ff + 4'h1;
    end
  end
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_soft_with_hard: assert property (hard_reset_line_oe_o |-> soft_reset_line_oe_o)
    else $error("soft line not pulled with hard line");
  a_hard_pull_low: assert property (hard_reset_line_oe_o |-> !hard_reset_line_n_o)
    else $error("hard line driven high");
  a_soft_pull_low: assert property (soft_reset_line_oe_o |-> !soft_reset_line_n_o)
    else $error("soft line driven high");
  a_hard_resets_cores: assert property (hard_reset_line_oe_o |-> core_reset_o)
    else $error("cores not reset in hard reset");
  a_soft_resets_cores: assert property (soft_reset_line_oe_o |-> core_reset_o)
    else $error("cores not reset in soft reset");
  a_pll_power_only: assert property ($rose(pll_reset_o) |-> por_age_ff < 4'h8)
    else $error("PLL reset outside power-on");
  a_boot_power_only: assert property ($changed(boot_configuration_word_o) |-> por_age_ff < 4'h8)
    else $error("boot word changed outside power-on");
  a_src_power_only: assert property ($changed(cfg_src_sel_o) |-> por_age_ff < 4'h8)
    else $error("source select changed outside power-on");
  a_hard_length: assert property ($fell(hard_reset_line_oe_o) && por_age_ff == 4'hf
    |-> hard_cnt_ff == 16'(P_HARD_CYC))
    else $error("hard drive length wrong");
  a_soft_length: assert property ($fell(soft_reset_line_oe_o) && !$past(hard_reset_line_oe_o)
    && por_age_ff == 4'hf |-> soft_cnt_ff == 16'(P_SOFT_CYC))
    else $error("soft drive length wrong");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");
endmodule

bind rsc_ctrl rsc_ctrl_props #(.P_HARD_CYC(P_HARD_CYC), .P_SOFT_CYC(P_SOFT_CYC)) rsc_ctrl_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .power_on_reset_n_i(power_on_reset_n_i), .hard_reset_line_n_o(hard_reset_line_n_o),
  .hard_reset_line_oe_o(hard_reset_line_oe_o), .soft_reset_line_n_o(soft_reset_line_n_o),
  .soft_reset_line_oe_o(soft_reset_line_oe_o), .core_reset_o(core_reset_o),
  .pll_reset_o(pll_reset_o), .cfg_src_sel_o(cfg_src_sel_o),
  .boot_configuration_word_o(boot_configuration_word_o));

// [bench/rsc_ctrl_test.sv]
// Self-checking testbench of the multi-source reset controller
`timescale 1ns/1ps
module rsc_ctrl_test;
  import rsc_pkg::*;
  localparam int GRD = 3;
  localparam logic [31:0] BW_A = 32'h5a3c0f81;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
  logic por_hold = 1'b0, pull_hard = 1'b0, pull_soft = 1'b0, wdog = 1'b0, tap = 1'b0, rio = 1'b0;
  logic por_n, hard_n, soft_n, hard_drv_n, hard_oe, soft_drv_n, soft_oe, core_rst, pll_rst;
  logic [7:0] cfg_pins = 8'h2d;
  logic [31:0] boot_word = BW_A, boot_out, sys_cfg;
  logic [2:0] src_sel;
  int n_errors = 0, cmp_count = 0;

  rsc_ctrl #(.P_POR_CYC(4), .P_HARD_CYC(4), .P_SOFT_CYC(4), .P_GUARD_CYC(GRD)) rsc_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .power_on_reset_n_i(por_n), .hard_reset_line_n_i(hard_n),
    .hard_reset_line_n_o(hard_drv_n), .hard_reset_line_oe_o(hard_oe),
    .soft_reset_line_n_i(soft_n), .soft_reset_line_n_o(soft_drv_n),
    .soft_reset_line_oe_o(soft_oe), .cfg_pins_i(cfg_pins), .boot_word_i(boot_word),
    .wdog_zero_i(wdog), .tap_soft_req_i(tap), .rio_hard_req_i(rio), .core_reset_o(core_rst),
    .pll_reset_o(pll_rst), .cfg_src_sel_o(src_sel), .boot_configuration_word_o(boot_out),
    .sys_cfg_o(sys_cfg));
  rsc_board_model rsc_board_model_inst (
    .por_hold_i(por_hold), .pull_hard_i(pull_hard), .pull_soft_i(pull_soft),
    .hard_oe_i(hard_oe), .hard_drv_n_i(hard_drv_n), .soft_oe_i(soft_oe),
    .soft_drv_n_i(soft_drv_n), .power_on_reset_n_o(por_n), .hard_line_n_o(hard_n),
    .soft_line_n_o(soft_n));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Request stands until the rising edge that samples ack high; data is taken there
  task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hf;
    wb_adr <= a;
    wb_dat_w <= d;
    @(posedge clk_i);
    while (wb_ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk(n < 20, 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_sel <= 4'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task pulse_src(input int k);
    @(posedge clk_i);
    wdog <= (k == 0);
    tap <= (k == 1);
    rio <= (k == 2);
    @(posedge clk_i);
    {wdog, tap, rio} <= 3'b000;
  endtask
  task pull(input logic hard, input int n);
    @(posedge clk_i);
    pull_hard <= hard;
    pull_soft <= !hard;
    repeat (n) @(posedge clk_i);
    pull_hard <= 1'b0;
    pull_soft <= 1'b0;
  endtask
  // Waits out one whole sequence, then checks its kind and the recorded sources
  task run_seq(input logic exp_hard, input logic exp_pll, input logic [8:0] exp_stat);
    int n;
    logic saw_hard, saw_pll;
    n = 0;
    saw_hard = 1'b0;
    saw_pll = 1'b0;
    while (soft_oe !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk(core_rst, 1'b1);
    while (soft_oe === 1'b1 && n < 400) begin
      saw_hard |= hard_oe;
      saw_pll |= pll_rst;
      @(negedge clk_i);
      n++;
    end
    chk(saw_hard, exp_hard);
    chk(saw_pll, exp_pll);
    repeat (GRD + 2) @(negedge clk_i);
    rd_chk(ADR_STAT, {23'h0, exp_stat});
  endtask
  task quiet(input int n);
    logic saw;
    saw = 1'b0;
    repeat (n) begin
      @(negedge clk_i);
      saw |= soft_oe;
    end
    chk(saw, 1'b0);
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task t_regs;
    rd_chk(ADR_CTRL, 32'h4);
    rd_chk(ADR_STAT, 32'h0);
    wr(8'h10, 32'hffffffff);
    rd_chk(8'h10, 32'h0);
    rd_chk(ADR_CTRL, 32'h4);
    $display("t_regs done");
  endtask
  task t_por;
    @(posedge clk_i);
    por_hold <= 1'b1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    chk({pll_rst, hard_oe, soft_oe, core_rst}, 4'hf);
    @(posedge clk_i);
    por_hold <= 1'b0;
    run_seq(1'b1, 1'b1, 9'h001);
    chk(boot_out, BW_A);
    chk(src_sel, 3'h5);
    rd_chk(ADR_BOOT, BW_A);
    $display("t_por done");
  endtask
  task t_sw;
    boot_word <= 32'h1234abcd;
    cfg_pins <= 8'h42;
    wr(ADR_CTRL, 32'h5);
    run_seq(1'b1, 1'b0, 9'h040);
    chk(boot_out, BW_A);
    chk(src_sel, 3'h5);
    chk(sys_cfg, BW_A);
    wr(ADR_CTRL, 32'h6);
    run_seq(1'b0, 1'b0, 9'h080);
    chk(sys_cfg, BW_A);
    wr(ADR_CTRL, 32'h7);
    run_seq(1'b1, 1'b0, 9'h0c0);
    $display("t_sw done");
  endtask
  task t_ext;
    pull(1'b1, 3);
    run_seq(1'b1, 1'b0, 9'h002);
    pull(1'b0, 3);
    run_seq(1'b0, 1'b0, 9'h004);
    pulse_src(1);
    while (soft_oe !== 1'b1) @(negedge clk_i);
    pull(1'b0, 2);
    run_seq(1'b0, 1'b0, 9'h010);
    quiet(20);
    $display("t_ext done");
  endtask
  task t_internal;
    logic [8:0] exp_stat [3] = '{9'h008, 9'h010, 9'h020};
    for (int k = 0; k < 3; k++) begin
      pulse_src(k);
      run_seq(k != 1, 1'b0, exp_stat[k]);
    end
    wr(ADR_CTRL, 32'h0);
    pulse_src(0);
    quiet(30);
    rd_chk(ADR_CTRL, 32'h0);
    wr(ADR_CTRL, 32'h4);
    rd_chk(ADR_CTRL, 32'h4);
    $display("t_internal done");
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_por();
    t_sw();
    t_ext();
    t_internal();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("Watchdog expired");
    end_sim();
  end
endmodule
